/* shared/iosr_pkg.sv */
package iosr_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          CHAN_N          = 16;
  localparam int          GROUP_N         = 2;
  // Register byte addresses
  localparam logic [11:0] OFF_FAULT       = 12'h000;
  localparam logic [11:0] OFF_ID_LO       = 12'h004;
  localparam logic [11:0] OFF_ID_HI       = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT    = 12'h00C;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h010;
  // Field positions in the fault status word
  localparam int          FLT_LOW_BIT     = 0;
  localparam int          FLT_HIGH_BIT    = 1;
  localparam int          FLT_W           = 2;
  // Reset values
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;
  localparam logic [1:0]  IRQ_STAT_RST    = 2'h0;
  // Identification code, arbitrary neutral value
  localparam logic [31:0] MODULE_ID_DFLT  = 32'h0000_0A5C;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* design/iosr_sync.sv */
module iosr_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         en_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } iosr_sync_t;

  iosr_sync_t st_q;
  iosr_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else if (en_in) begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.s2;
endmodule

/* design/iosr_fault_map.sv */
module iosr_fault_map
  import iosr_pkg::*;
(
  input  wire logic [iosr_pkg::CHAN_N-1:0] flt_in,
  output logic      [iosr_pkg::FLT_W-1:0]  grp_out
);
  // One bit per group of eight output channels
  genvar g;
  generate
    for (g = 0; g < GROUP_N; g++) begin : g_grp
      assign grp_out[g] = |flt_in[g*(CHAN_N/GROUP_N) +: (CHAN_N/GROUP_N)];
    end
  endgenerate
endmodule

/* design/iosr_top.sv */
// Functional notes
// - Bit 0 is high while any output 1 to 8 is shorted or overloaded.
// - Bit 1 is high while any output 9 to 16 is shorted or overloaded.
// - Fault bits clear by themselves when the fault is gone.
// - Status is read-only and after reset shows current faults.
// - A fixed module identification code is readable in two registers.
//
// Added by the designer: register access over AXI4-Lite.
module iosr_top
  import iosr_pkg::*;
#(
  parameter logic [31:0] MODULE_ID = iosr_pkg::MODULE_ID_DFLT
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        clk_en_in,
  input  wire logic [iosr_pkg::CHAN_N-1:0] out_fault_in,
  input  wire logic [iosr_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                        s_axi_awvalid_in,
  output logic                             s_axi_awready_out,
  input  wire logic [iosr_pkg::DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [3:0]                  s_axi_wstrb_in,
  input  wire logic                        s_axi_wvalid_in,
  output logic                             s_axi_wready_out,
  output logic      [1:0]                  s_axi_bresp_out,
  output logic                             s_axi_bvalid_out,
  input  wire logic                        s_axi_bready_in,
  input  wire logic [iosr_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                        s_axi_arvalid_in,
  output logic                             s_axi_arready_out,
  output logic      [iosr_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic      [1:0]                  s_axi_rresp_out,
  output logic                             s_axi_rvalid_out,
  input  wire logic                        s_axi_rready_in,
  output logic      [iosr_pkg::FLT_W-1:0]  fault_status_out,
  output logic                             irq_out
);
  import iosr_pkg::*;

  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic [FLT_W-1:0]  fault;
    logic [FLT_W-1:0]  fault_prev;
    logic [FLT_W-1:0]  irq_stat;
    logic [FLT_W-1:0]  irq_mask;
  } iosr_state_t;

  iosr_state_t st_q;
  iosr_state_t st_d;

  logic [CHAN_N-1:0] flt_sync;
  logic [FLT_W-1:0]  grp_fault;

  // Fault pins are asynchronous to the bus clock
  iosr_sync #(
    .W(CHAN_N)
  ) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .en_in  (clk_en_in),
    .d_in   (out_fault_in),
    .q_out  (flt_sync)
  );

  iosr_fault_map u_map (
    .flt_in  (flt_sync),
    .grp_out (grp_fault)
  );

  logic do_wr;
  logic do_rd;
  logic [FLT_W-1:0] w1c;
  logic [FLT_W-1:0] rise;

  always_comb begin
    st_d = st_q;
    w1c  = '0;
    // Level follows the live fault, no latch, so removal clears it
    st_d.fault      = grp_fault;
    st_d.fault_prev = st_q.fault;
    rise            = st_q.fault & ~st_q.fault_prev;

    if (s_axi_awvalid_in && !st_q.aw_held) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_q.w_held) begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata_in;
      st_d.w_strb = s_axi_wstrb_in;
    end

    do_wr = st_q.aw_held && st_q.w_held && !st_q.bvalid;
    if (do_wr) begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = RESP_OKAY;
      case ({st_q.aw_addr[ADDR_W-1:2], 2'b00})
        OFF_IRQ_MASK: begin
          if (st_q.w_strb[0]) begin
            st_d.irq_mask = st_q.w_data[FLT_W-1:0];
          end
        end
        OFF_IRQ_STAT: begin
          if (st_q.w_strb[0]) begin
            w1c = st_q.w_data[FLT_W-1:0];
          end
        end
        // Read-only registers accept and ignore writes
        OFF_FAULT, OFF_ID_LO, OFF_ID_HI: st_d.bresp = RESP_OKAY;
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready_in) begin
      st_d.bvalid = 1'b0;
    end

    // New fault edge wins over a same-cycle clear
    st_d.irq_stat = (st_q.irq_stat & ~w1c) | rise;

    do_rd = s_axi_arvalid_in && !st_q.rvalid;
    if (do_rd) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      st_d.rdata  = '0;
      case ({s_axi_araddr_in[ADDR_W-1:2], 2'b00})
        OFF_FAULT:    st_d.rdata[FLT_W-1:0] = st_q.fault;
        OFF_ID_LO:    st_d.rdata = MODULE_ID;
        OFF_ID_HI:    st_d.rdata = MODULE_ID;
        OFF_IRQ_STAT: st_d.rdata[FLT_W-1:0] = st_q.irq_stat;
        OFF_IRQ_MASK: st_d.rdata[FLT_W-1:0] = st_q.irq_mask;
        default:      st_d.rresp = RESP_SLVERR;
      endcase
    end
    if (st_q.rvalid && s_axi_rready_in) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q          <= '0;
      st_q.irq_mask <= IRQ_MASK_RST;
      st_q.irq_stat <= IRQ_STAT_RST;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready_out = clk_en_in && !st_q.aw_held;
  assign s_axi_wready_out  = clk_en_in && !st_q.w_held;
  assign s_axi_bvalid_out  = st_q.bvalid;
  assign s_axi_bresp_out   = st_q.bresp;
  assign s_axi_arready_out = clk_en_in && !st_q.rvalid;
  assign s_axi_rvalid_out  = st_q.rvalid;
  assign s_axi_rresp_out   = st_q.rresp;
  assign s_axi_rdata_out   = st_q.rdata;
  assign fault_status_out  = st_q.fault;
  assign irq_out           = |(st_q.irq_stat & st_q.irq_mask);
endmodule

/* verification/iosr_top_asserts.sv */
module iosr_top_asserts
  import iosr_pkg::*;
#(parameter logic [31:0] MODULE_ID = 32'h0) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [15:0] out_fault_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [1:0]  fault_status_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [1:0]  up_q;
  logic [11:0] ar_q;
  // Pin sync needs three clean edges after reset before the flags track
  always_ff @(posedge clk_in) begin
    up_q <= rst_in ? 2'h0 : up_q + {1'b0, up_q != 2'h3};
    if (s_axi_arvalid_in && s_axi_arready_out)
      ar_q <= s_axi_araddr_in;
  end
  grp_low_a: assert property (
    up_q == 2'h3 |-> fault_status_out[0] == |$past(out_fault_in[7:0], 3))
    else $error("low flag wrong");
  grp_high_a: assert property (
    up_q == 2'h3 |-> fault_status_out[1] == |$past(out_fault_in[15:8], 3))
    else $error("high flag wrong");
  stat_zero_a: assert property (
    s_axi_rvalid_out && ar_q == OFF_FAULT |-> s_axi_rdata_out[31:2] == 30'h0)
    else $error("status upper bits set");
  stat_live_a: assert property (
    $rose(s_axi_rvalid_out) && ar_q == OFF_FAULT |->
      s_axi_rdata_out[1:0] == $past(fault_status_out))
    else $error("status read stale");
  id_code_a: assert property (
    s_axi_rvalid_out && (ar_q == OFF_ID_LO || ar_q == OFF_ID_HI) |->
      s_axi_rdata_out == MODULE_ID)
    else $error("module id wrong");
  bad_addr_a: assert property (
    s_axi_rvalid_out && {ar_q[11:2], 2'b00} > OFF_IRQ_MASK |->
      s_axi_rresp_out == RESP_SLVERR)
    else $error("unmapped read accepted");
endmodule

/* verification/iosr_load_model.sv */
module iosr_load_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] short_in,
  output logic      [15:0] fault_out = 16'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk_in) fault_out <= short_in;
endmodule

/* verification/iosr_tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iosr_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1, s_axi_bready_in = 1'b1;
  logic s_axi_rready_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, irq_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, fault_status_out, r;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
  logic [15:0] sh = 16'h8001, out_fault_in;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, d;
  int          fails = 0, n_compared = 0, cyc = 0;
  iosr_load_model u_load (.clk_in, .short_in(sh), .fault_out(out_fault_in));
  iosr_top dut (.*);
  initial forever #50 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Handshakes are judged at the falling edge: ready and valid are settled there and
  // cannot change before the next rising edge, so no race with the design's update
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic pa = 1'b1, pw = 1'b1, ha, hw;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    // Address and data may be taken on different edges
    while (pa || pw) begin
      @(negedge clk_in);
      ha = s_axi_awready_out;
      hw = s_axi_wready_out;
      @(posedge clk_in);
      pa = pa && !ha;
      pw = pw && !hw;
      s_axi_awvalid_in <= pa;
      s_axi_wvalid_in <= pw;
    end
    do @(negedge clk_in); while (!s_axi_bvalid_out);
    r = s_axi_bresp_out;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a);
    logic hs;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do begin
      @(negedge clk_in);
      hs = s_axi_arready_out;
      @(posedge clk_in);
    end while (!hs);
    s_axi_arvalid_in <= 1'b0;
    do @(negedge clk_in); while (!s_axi_rvalid_out);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    @(posedge clk_in);
  endtask
  task automatic s_regs;
    repeat (5) @(posedge clk_in);
    rd(OFF_FAULT);
    chk("rst_stat", 32'h3, d);
    wr(OFF_FAULT, 32'h0);
    chk("ro_wr_rsp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(OFF_FAULT);
    chk("ro_stat", 32'h3, d);
    rd(OFF_ID_LO);
    chk("id_lo", MODULE_ID_DFLT, d);
    rd(OFF_ID_HI);
    chk("id_hi", MODULE_ID_DFLT, d);
    rd(12'h100);
    chk("bad_rsp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(12'h100, 32'h0);
    chk("bad_wr_rsp", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask
  task automatic s_groups;
    for (int c = 0; c < 16; c++) begin
      sh <= 16'h1 << c;
      repeat (5) @(posedge clk_in);
      rd(OFF_FAULT);
      chk("grp_rd", {30'h0, c > 7, c < 8}, d);
      chk("grp_pin", {30'h0, c > 7, c < 8}, {30'h0, fault_status_out});
      sh <= 16'h0;
      repeat (5) @(posedge clk_in);
      rd(OFF_FAULT);
      chk("grp_clr", 32'h0, d);
    end
  endtask
  task automatic s_irq;
    wr(OFF_IRQ_STAT, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1);
    sh <= 16'h0010;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    chk("irq_on", 32'h1, {31'h0, irq_out});
    wr(OFF_IRQ_MASK, 32'h0);
    chk("irq_mask", 32'h0, {31'h0, irq_out});
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    chk("irq_clr", 32'h0, {31'h0, irq_out});
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    s_regs();
    s_groups();
    s_irq();
    complete_run();
  end
endmodule
bind iosr_top iosr_top_asserts #(.MODULE_ID(MODULE_ID)) u_chk (.*);
